// ### verilog/lcd_host_port_pkg.sv
package lcd_host_port_pkg;

  // ****************************************
  // bus styles and strap encodings
  // ****************************************
  typedef enum logic [1:0] {
    STYLE_GENERIC = 2'h0,
    STYLE_ENABLE_CLOCK = 2'h1,
    STYLE_DATA_STROBE = 2'h2,
    STYLE_RESERVED = 2'h3
  } bus_style_type;

  typedef enum logic [1:0] {
    KIND_NONE = 2'h0,
    KIND_COMMAND = 2'h1,
    KIND_PARAMETER = 2'h2,
    KIND_STATUS = 2'h3
  } byte_kind_type;

  localparam logic ADDR_MODE_INDIRECT = 1'h0;
  localparam logic ADDR_MODE_DIRECT = 1'h1;

  // ****************************************
  // clock limits and host timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int IN_CLK_MAX_MHZ = 60;
  localparam int SHIFT_CLK_MAX_MHZ = 15;
  localparam int HOST_STROBE_NS = 200;
  localparam int HOST_STROBE_CYCLES = (HOST_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOST_SETUP_NS = 60;
  localparam int HOST_SETUP_CYCLES = (HOST_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [14:0] UPPER_ADDR_RESET = 15'h0000;

endpackage : lcd_host_port_pkg

// ### verilog/lcd_host_bus_if.sv
`timescale 1ns/100ps
interface lcd_host_bus_if;
  logic [15:1] upperAddr;
  logic lowAddressBit;
  logic chipSelectN;
  logic readPin;
  logic writePin;
  logic [7:0] hostData;
  logic hostDataOe;
  logic [7:0] devData;
  logic devDataOe;
  logic [1:0] shiftPeriodStraps;
  logic [1:0] busStyleStraps;
  logic addressingModeStrap;
  wire [7:0] dataBus;

  // resolved bus level from the two enables
  assign dataBus = devDataOe ? devData : (hostDataOe ? hostData : 8'hFF);

  modport device (
    input upperAddr, lowAddressBit, chipSelectN, readPin, writePin,
    input hostData, hostDataOe, shiftPeriodStraps, busStyleStraps, addressingModeStrap,
    output devData, devDataOe
  );

  modport host (
    output upperAddr, lowAddressBit, chipSelectN, readPin, writePin,
    output hostData, hostDataOe, shiftPeriodStraps, busStyleStraps, addressingModeStrap,
    input devData, devDataOe, dataBus
  );
endinterface : lcd_host_bus_if

// ### verilog/lcd_host_port_device.sv
`timescale 1ns/100ps
module lcd_host_port_device (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // host bus
  lcd_host_bus_if.device bus,
  // controller side
  output logic wrValid,
  output logic [15:0] wrAddr,
  output logic [7:0] wrData,
  output lcd_host_port_pkg::byte_kind_type wrKind,
  output logic rdStart,
  output logic [15:0] rdAddr,
  output lcd_host_port_pkg::byte_kind_type rdKind,
  input wire logic [7:0] rdData,
  output logic [1:0] shiftPeriod,
  output lcd_host_port_pkg::bus_style_type busStyle,
  output logic directMode
);
  import lcd_host_port_pkg::*;

  // ****************************************
  // two-stage synchronisers
  // ****************************************
  localparam int SW = 8 + 15 + 1 + 3 + 5;
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  logic [SW-1:0] rawIn;
  assign rawIn = {bus.hostData, bus.upperAddr, bus.lowAddressBit, bus.chipSelectN,
                  bus.readPin, bus.writePin, bus.shiftPeriodStraps, bus.busStyleStraps,
                  bus.addressingModeStrap};

  // every pin passes two flops before use; no reset here, so the true
  // pin levels (select high, straps) are in place when reset lifts
  always_ff @(posedge core_clk) begin
    sync1_q <= rawIn;
    sync2_q <= sync1_q;
  end

  wire [7:0] sData = sync2_q[31:24];
  wire [14:0] sUpper = sync2_q[23:9];
  wire sLow = sync2_q[8];
  wire sCsN = sync2_q[7];
  wire sRd = sync2_q[6];
  wire sWr = sync2_q[5];
  wire [1:0] sShift = sync2_q[4:3];
  wire [1:0] sStyle = sync2_q[2:1];
  wire sMode = sync2_q[0];

  // ****************************************
  // strap capture after reset release
  // ****************************************
  logic [1:0] shift_q;
  logic [1:0] style_q;
  logic mode_q;
  logic [1:0] strapWait_q;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      strapWait_q <= 2'h0;
      shift_q <= 2'h0;
      style_q <= 2'h0;
      mode_q <= ADDR_MODE_INDIRECT;
    end else if (strapWait_q != 2'h3) begin
      strapWait_q <= strapWait_q + 2'h1;
      shift_q <= sShift;
      style_q <= sStyle;
      mode_q <= sMode;
    end
  end

  // ****************************************
  // strobe decoding per style
  // ****************************************
  logic rdPrev_q;
  logic wrPrev_q;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdPrev_q <= 1'h1;
      wrPrev_q <= 1'h1;
    end else begin
      rdPrev_q <= sRd;
      wrPrev_q <= sWr;
    end
  end

  wire selected = ~sCsN;
  wire isGeneric = style_q == STYLE_GENERIC;
  wire isEclk = style_q == STYLE_ENABLE_CLOCK;
  wire isDs = style_q == STYLE_DATA_STROBE;
  wire rdRise = sRd & ~rdPrev_q;
  wire rdFall = ~sRd & rdPrev_q;
  wire genWrite = isGeneric & selected & sWr & ~wrPrev_q;
  wire genRead = isGeneric & selected & ~sRd;
  wire genRdStart = genRead & rdPrev_q;
  wire busEvent = (isEclk & rdRise) | (isDs & rdFall);
  wire altWrite = busEvent & selected & ~sWr;
  wire altRead = busEvent & selected & sWr;
  wire altReadHold = selected & sWr & ((isEclk & sRd) | (isDs & ~sRd));

  // full address in direct mode, bit zero only otherwise
  wire [15:0] decAddr = (mode_q == ADDR_MODE_DIRECT) ? {sUpper, sLow}
                                                     : {15'h0000, sLow};
  // byte kind from bit zero and direction
  function automatic byte_kind_type kindOf(input logic a0, input logic isRead);
    kindOf = isRead ? (a0 ? KIND_PARAMETER : KIND_STATUS)
                    : (a0 ? KIND_COMMAND : KIND_PARAMETER);
  endfunction

  // ****************************************
  // controller-side registers and data drive
  // ****************************************
  logic driving_d;
  assign driving_d = genRead | altReadHold;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wrValid <= 1'h0;
      wrAddr <= 16'h0000;
      wrData <= DATA_RESET;
      wrKind <= KIND_NONE;
      rdStart <= 1'h0;
      rdAddr <= 16'h0000;
      rdKind <= KIND_NONE;
      bus.devData <= DATA_RESET;
      bus.devDataOe <= 1'h0;
    end else begin
      wrValid <= genWrite | altWrite;
      rdStart <= genRdStart | altRead;
      if (genWrite | altWrite) begin
        wrAddr <= decAddr;
        wrData <= sData;
        wrKind <= kindOf(sLow, 1'b0);
      end
      if (genRdStart | altRead) begin
        rdAddr <= decAddr;
        rdKind <= kindOf(sLow, 1'b1);
      end
      bus.devData <= rdData;
      bus.devDataOe <= driving_d;
    end
  end

  assign shiftPeriod = shift_q;
  assign busStyle = bus_style_type'(style_q);
  assign directMode = mode_q;
endmodule : lcd_host_port_device

// ### verilog/lcd_host_port_host.sv
`timescale 1ns/100ps
module lcd_host_port_host (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // host bus
  lcd_host_bus_if.host bus,
  // user side
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [15:0] reqAddr,
  input wire logic [7:0] reqData,
  output logic reqReady,
  output logic rspValid,
  output logic [7:0] rspData,
  // strap settings driven to the device
  input wire logic [1:0] cfgShift,
  input wire lcd_host_port_pkg::bus_style_type cfgStyle,
  input wire logic cfgDirect
);
  import lcd_host_port_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SETUP = 2'h1,
    ST_STROBE = 2'h2,
    ST_HOLD = 2'h3
  } host_state_type;

  host_state_type state_q;
  logic [7:0] cnt_q;
  logic write_q;
  logic [15:0] addr_q;
  logic [7:0] wdata_q;
  logic [7:0] din1_q;
  logic [7:0] din2_q;

  // ****************************************
  // strobe levels per style
  // ****************************************
  wire active = state_q == ST_STROBE;
  wire [7:0] setupLast = 8'(HOST_SETUP_CYCLES - 1);
  wire [7:0] strobeLast = 8'(HOST_STROBE_CYCLES + 3);
  wire rdLevel = (cfgStyle == STYLE_ENABLE_CLOCK) ? active
               : (cfgStyle == STYLE_DATA_STROBE) ? ~active
               : ~(active & ~write_q);
  wire wrLevel = (cfgStyle == STYLE_GENERIC) ? ~(active & write_q)
               : ~write_q;

  // ****************************************
  // transfer sequencer
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
      cnt_q <= 8'h00;
      write_q <= 1'h0;
      addr_q <= 16'h0000;
      wdata_q <= DATA_RESET;
      rspValid <= 1'h0;
      rspData <= DATA_RESET;
    end else begin
      rspValid <= 1'h0;
      unique case (state_q)
        ST_IDLE: begin
          cnt_q <= 8'h00;
          if (reqValid) begin
            write_q <= reqWrite;
            addr_q <= cfgDirect ? reqAddr : {15'h0000, reqAddr[0]};
            wdata_q <= reqData;
            state_q <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q == setupLast) begin
            cnt_q <= 8'h00;
            state_q <= ST_STROBE;
          end
        end
        ST_STROBE: begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q == strobeLast) begin
            cnt_q <= 8'h00;
            state_q <= ST_HOLD;
            rspValid <= ~write_q;
            rspData <= din2_q;
          end
        end
        ST_HOLD: begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q == setupLast) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // read data passes two flops
  always_ff @(posedge core_clk) begin
    if (srst) begin
      din1_q <= DATA_RESET;
      din2_q <= DATA_RESET;
    end else begin
      din1_q <= bus.dataBus;
      din2_q <= din1_q;
    end
  end

  // ****************************************
  // pin drive
  // ****************************************
  // straps are board ties: they follow the settings through reset too,
  // so the device sees them settled before it captures them
  always_ff @(posedge core_clk) begin
    bus.shiftPeriodStraps <= cfgShift;
    bus.busStyleStraps <= cfgStyle;
    bus.addressingModeStrap <= cfgDirect;
  end

  // strobes, select, address and write data
  always_ff @(posedge core_clk) begin
    if (srst) begin
      bus.chipSelectN <= 1'h1;
      bus.readPin <= 1'h1;
      bus.writePin <= 1'h1;
      bus.upperAddr <= UPPER_ADDR_RESET;
      bus.lowAddressBit <= 1'h0;
      bus.hostData <= DATA_RESET;
      bus.hostDataOe <= 1'h0;
      reqReady <= 1'h0;
    end else begin
      bus.chipSelectN <= state_q == ST_IDLE;
      bus.readPin <= (cfgStyle == STYLE_GENERIC && state_q == ST_IDLE) ? 1'h1 : rdLevel;
      bus.writePin <= wrLevel;
      bus.upperAddr <= addr_q[15:1];
      bus.lowAddressBit <= addr_q[0];
      bus.hostData <= wdata_q;
      bus.hostDataOe <= write_q & (state_q != ST_IDLE);
      reqReady <= state_q == ST_IDLE && !reqValid;
    end
  end
endmodule : lcd_host_port_host

// ### dv/lcd_host_port_checker.sv
`timescale 1ns/100ps
module lcd_host_port_checker
  import lcd_host_port_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // bus pins
  input wire logic [15:1] upperAddr,
  input wire logic chipSelectN,
  input wire logic readPin,
  input wire logic writePin,
  input wire logic hostDataOe,
  input wire logic devDataOe,
  // straps
  input wire logic [1:0] shiftPeriodStraps,
  input wire logic [1:0] busStyleStraps,
  input wire logic addressingModeStrap
);
  // ****************************************
  // bus pin checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  // style decodes
  wire isGeneric = busStyleStraps == STYLE_GENERIC;
  wire isEnClk = busStyleStraps == STYLE_ENABLE_CLOCK;
  wire isStrobe = busStyleStraps == STYLE_DATA_STROBE;

  // a generic write strobe stays low fourteen cycles
  sequence s_low14;
    !writePin [*8] ##1 !writePin [*6] ##1 writePin;
  endsequence
  property p_wr_strobe; $fell(writePin) && isGeneric |-> s_low14; endproperty
  property p_oe_cs; devDataOe |-> $past(chipSelectN, 3) == 1'b0; endproperty
  property p_oe_dir; devDataOe |-> $past(writePin, 3); endproperty
  property p_oe_gen; devDataOe && isGeneric |-> !$past(readPin, 3); endproperty
  property p_oe_ec; devDataOe && isEnClk |-> $past(readPin, 3); endproperty
  property p_oe_ds; devDataOe && isStrobe |-> !$past(readPin, 3); endproperty
  property p_no_fight; !(devDataOe && hostDataOe); endproperty
  property p_upper_gnd; !chipSelectN && !addressingModeStrap |-> upperAddr == 15'h0000;
  endproperty
  property p_straps;
    $stable({shiftPeriodStraps, busStyleStraps, addressingModeStrap});
  endproperty

  a_wr_strobe: assert property (p_wr_strobe) else $error("write strobe length");
  a_oe_cs: assert property (p_oe_cs) else $error("drive without select");
  a_oe_dir: assert property (p_oe_dir) else $error("drive on write");
  a_oe_gen: assert property (p_oe_gen) else $error("drive without read");
  a_oe_ec: assert property (p_oe_ec) else $error("drive without enable");
  a_oe_ds: assert property (p_oe_ds) else $error("drive without strobe");
  a_no_fight: assert property (p_no_fight) else $error("bus contention");
  a_upper_gnd: assert property (p_upper_gnd) else $error("upper not ground");
  a_straps: assert property (p_straps) else $error("straps moved");
endmodule : lcd_host_port_checker

// ### dv/lcd_host_port_tb.sv
`timescale 1ns/100ps
module lcd_host_port_tb;
  import lcd_host_port_pkg::*;
  // ****************************************
  // bench signals and model
  // ****************************************
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic reqValid = 1'b0;
  logic reqWrite = 1'b0;
  logic [15:0] reqAddr = 16'h0000;
  logic [7:0] reqData = 8'h00;
  logic [7:0] rdData = 8'h00;
  logic [7:0] rnd = 8'h3A;
  logic [1:0] cfgShift = 2'h0;
  bus_style_type cfgStyle = STYLE_GENERIC;
  logic cfgDirect = 1'b0;
  logic reqReady, rspValid, wrValid, rdStart, directMode;
  logic [7:0] rspData, wrData;
  logic [15:0] wrAddr, rdAddr;
  byte_kind_type wrKind, rdKind;
  logic [1:0] shiftPeriod;
  bus_style_type busStyle;
  int n_mismatch = 0;
  int comparisons = 0;
  int ent;
  int wq[$], rq[$], dq[$];

  always #10 core_clk = ~core_clk;

  lcd_host_bus_if hostBus ();
  lcd_host_port_host u_lcd_host_port_host (.core_clk(core_clk), .srst(srst), .bus(hostBus),
    .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData),
    .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData), .cfgShift(cfgShift),
    .cfgStyle(cfgStyle), .cfgDirect(cfgDirect));
  lcd_host_port_device u_lcd_host_port_device (.core_clk(core_clk), .srst(srst),
    .bus(hostBus), .wrValid(wrValid), .wrAddr(wrAddr), .wrData(wrData), .wrKind(wrKind),
    .rdStart(rdStart), .rdAddr(rdAddr), .rdKind(rdKind), .rdData(rdData),
    .shiftPeriod(shiftPeriod), .busStyle(busStyle), .directMode(directMode));
  lcd_host_port_checker u_lcd_host_port_checker (.core_clk(core_clk), .srst(srst),
    .upperAddr(hostBus.upperAddr), .chipSelectN(hostBus.chipSelectN),
    .readPin(hostBus.readPin), .writePin(hostBus.writePin),
    .hostDataOe(hostBus.hostDataOe), .devDataOe(hostBus.devDataOe),
    .shiftPeriodStraps(hostBus.shiftPeriodStraps), .busStyleStraps(hostBus.busStyleStraps),
    .addressingModeStrap(hostBus.addressingModeStrap));

  task automatic chk(input bit ok, input string what);
    comparisons++;
    if (!ok) begin
      n_mismatch++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask : chk

  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  // reset with new straps, then check the captured copies
  task automatic restart(input bus_style_type s, input logic d);
    @(negedge core_clk);
    srst = 1'b1;
    cfgStyle = s;
    cfgDirect = d;
    rnd = lfsr(rnd);
    cfgShift = rnd[1:0];
    repeat (12) @(negedge core_clk);
    srst = 1'b0;
    repeat (8) @(negedge core_clk);
    chk(shiftPeriod === cfgShift, "shift");
    chk(busStyle === s, "style");
    chk(directMode === d, "mode");
  endtask : restart

  // one host transfer; the model queues what the device must report
  task automatic xfer(input logic w, input logic a0);
    byte_kind_type k;
    logic [15:0] ea;
    rnd = lfsr(rnd);
    reqAddr = {rnd, ~rnd[6:0], a0};
    reqData = ~rnd;
    rdData = rnd ^ 8'h5A;
    reqWrite = w;
    k = w ? (a0 ? KIND_COMMAND : KIND_PARAMETER) : (a0 ? KIND_PARAMETER : KIND_STATUS);
    ea = cfgDirect ? reqAddr : {15'h0000, a0};
    if (cfgStyle != STYLE_RESERVED && w) wq.push_back(int'({k, ea, reqData}));
    if (cfgStyle != STYLE_RESERVED && !w) rq.push_back(int'({k, ea}));
    // an undriven data bus reads all ones
    if (!w) dq.push_back(int'(cfgStyle == STYLE_RESERVED ? 8'hFF : rdData));
    reqValid = 1'b1;
    @(negedge core_clk);
    reqValid = 1'b0;
    for (int n = 0; n < 60 && wq.size() + rq.size() + dq.size() != 0; n++) @(negedge core_clk);
    chk(wq.size() + rq.size() + dq.size() == 0, "no result");
    for (int n = 0; n < 40 && reqReady !== 1'b1; n++) @(negedge core_clk);
    repeat (2) @(negedge core_clk);
    chk(hostBus.devDataOe === 1'b0, "bus held");
    if (cfgStyle != STYLE_RESERVED) chk(reqReady === 1'b1, "host stuck");
  endtask : xfer

  // compare every device and host result with the model (byte kinds in indirect mode only), away from the launch edge
  always @(negedge core_clk) begin
    if (wrValid === 1'b1) begin
      chk(wq.size() != 0, "stray write");
      ent = (wq.size() != 0) ? wq.pop_front() : 0;
      chk(wrData === ent[7:0], "write data");
      chk(wrAddr === ent[23:8], "write addr");
      if (!cfgDirect) chk(wrKind === ent[25:24], "write kind");
    end
    if (rdStart === 1'b1) begin
      ent = (rq.size() != 0) ? rq.pop_front() : 0;
      chk(rdAddr === ent[15:0], "read addr");
      if (!cfgDirect) chk(rdKind === ent[17:16], "read kind");
    end
    if (rspValid === 1'b1) begin
      ent = (dq.size() != 0) ? dq.pop_front() : 0;
      chk(rspData === ent[7:0], "read data");
    end
  end

  // every style in both addressing modes, each kind of byte (only one status read in the reserved style)
  initial begin
    for (int s = 0; s < 4; s++) begin
      for (int d = 0; d < 2; d++) begin
        restart(bus_style_type'(s), d[0]);
        for (int k = 0; k < (s == 3 ? 1 : 4); k++) xfer(k[1], k[0]);
        $display("test style %0d direct %0d done", s, d);
      end
    end
    wrap_up;
  end

  // the bench clock must stay within the input clock limit
  initial begin
    realtime t0;
    @(posedge core_clk);
    t0 = $realtime;
    @(posedge core_clk);
    chk(($realtime - t0) >= (1000.0 / IN_CLK_MAX_MHZ), "clock too fast");
  end

  // hang guard
  initial begin
    #(20 * 20000);
    n_mismatch++;
    wrap_up;
  end
endmodule : lcd_host_port_tb
